// [rtl/bal_alu.v]
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "bal_defines.vh"

// Behaviour
// - Add writes accumulator plus source
// - Add with carry includes current carry
// - Carry equals carry out of bit 7
// - Wrap flag is carry6 xor carry7
// - Half carry equals carry out of bit 3
// - Subtract source and carry from accumulator
// - Carry set on borrow out of bit 7
// - Wrap set on borrow at one of 6,7
// - Half carry set on borrow at bit 3
// - Multiply: low byte to A, high to B
// - Multiply clears carry, wrap if above 255
// - Divide: quotient to A, remainder to B
// - Divide clears carry, wrap on zero divisor
// - Adjust adds 06 on half carry/nibble>9
// - Adjust adds 60 on carry or step one
// - Adjust carry set when result above 99
// - Rotate right through carry
// - Rotate left through carry
// - Compare branches when operands differ
// - Compare carry set when source exceeds destination
module bal_alu (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         op_done,
    output reg         branch_taken
);

    reg  [7:0]             acc_r;
    reg  [7:0]             breg_r;
    reg  [7:0]             src_r;
    reg  [7:0]             dst_r;
    reg                    carry_r;
    reg                    half_r;
    reg                    wrap_r;
    reg  [`BAL_OP_W-1:0]   op_r;
    reg                    go_r;
    reg                    divzero_r;
    reg                    badop_r;

    reg  [7:0]             acc_nxt;
    reg  [7:0]             breg_nxt;
    reg                    carry_nxt;
    reg                    half_nxt;
    reg                    wrap_nxt;
    reg                    branch_nxt;
    reg                    divzero_nxt;
    reg                    badop_nxt;

    wire                   access;
    wire                   wr_commit;
    wire                   mapped;
    reg  [31:0]            rd_data;

    wire [10:0]            sum_v;
    wire [10:0]            dif_v;
    wire [15:0]            prod_v;
    wire [7:0]             quo_v;
    wire [7:0]             rem_v;
    reg                    da_step1;
    reg                    da_step2;
    reg  [9:0]             da_total;

    // Returns {carry7, carry6, carry3, result}; for subtraction the
    // carries are borrows, which is what every flag wants there
    function [10:0] addsub;
        input [7:0] a;
        input [7:0] b;
        input       cin;
        input       sub;
        reg   [4:0] lo;
        reg   [7:0] mid;
        reg   [8:0] full;
        begin
            if (sub) begin
                lo   = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
                mid  = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, cin};
                full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            end else begin
                lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
                mid  = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
                full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            end
            addsub = {full[8], mid[7], lo[4], full[7:0]};
        end
    endfunction

    function is_mapped;
        input [7:0] addr;
        begin
            case (addr)
                `BAL_ADDR_ACC, `BAL_ADDR_BREG, `BAL_ADDR_SRC,
                `BAL_ADDR_DST, `BAL_ADDR_FLAGS, `BAL_ADDR_CMD,
                `BAL_ADDR_STATUS: is_mapped = 1'b1;
                default:          is_mapped = 1'b0;
            endcase
        end
    endfunction

    // Plain add ignores the carry input entirely
    assign sum_v  = addsub(acc_r, src_r,
                           (op_r == `BAL_OP_SUM_WITH_CARRY_IN) & carry_r,
                           1'b0);
    assign dif_v  = addsub(acc_r, src_r, carry_r, 1'b1);
    assign prod_v = acc_r * breg_r;
    // Zero divisor is routed around the divider; A keeps its value and B stays zero
    assign quo_v  = (breg_r == 8'h00) ? acc_r : acc_r / breg_r;
    assign rem_v  = (breg_r == 8'h00) ? breg_r : acc_r % breg_r;

    always @* begin
        da_step1 = half_r | (acc_r[3:0] > `BAL_DA_NIB_MAX);
        da_step2 = carry_r | da_step1;
        da_total = {2'b00, acc_r}
                 + (da_step1 ? {2'b00, `BAL_DA_LOW_FIX} : 10'h000)
                 + (da_step2 ? {2'b00, `BAL_DA_HIGH_FIX} : 10'h000);
    end

    always @* begin
        acc_nxt     = acc_r;
        breg_nxt    = breg_r;
        carry_nxt   = carry_r;
        half_nxt    = half_r;
        wrap_nxt    = wrap_r;
        branch_nxt  = branch_taken;
        divzero_nxt = divzero_r;
        badop_nxt   = 1'b0;
        case (op_r)
            `BAL_OP_ADD, `BAL_OP_SUM_WITH_CARRY_IN: begin
                acc_nxt   = sum_v[7:0];
                carry_nxt = sum_v[10];
                wrap_nxt  = sum_v[10] ^ sum_v[9];
                half_nxt  = sum_v[8];
            end
            `BAL_OP_SUBTRACT_WITH_BORROW: begin
                acc_nxt   = dif_v[7:0];
                carry_nxt = dif_v[10];
                wrap_nxt  = dif_v[10] ^ dif_v[9];
                half_nxt  = dif_v[8];
            end
            `BAL_OP_MUL: begin
                acc_nxt   = prod_v[7:0];
                breg_nxt  = prod_v[15:8];
                carry_nxt = 1'b0;
                wrap_nxt  = prod_v > `BAL_MUL_MAX;
            end
            `BAL_OP_DIV: begin
                acc_nxt     = quo_v;
                breg_nxt    = rem_v;
                carry_nxt   = 1'b0;
                wrap_nxt    = (breg_r == 8'h00);
                divzero_nxt = (breg_r == 8'h00);
            end
            `BAL_OP_DA: begin
                acc_nxt   = da_total[7:0];
                carry_nxt = da_total > `BAL_DA_BCD_MAX;
            end
            `BAL_OP_RRC: begin
                acc_nxt   = {carry_r, acc_r[7:1]};
                carry_nxt = acc_r[0];
            end
            `BAL_OP_RLC: begin
                acc_nxt   = {acc_r[6:0], carry_r};
                carry_nxt = acc_r[7];
            end
            `BAL_OP_COMPARE_BRANCH_UNEQUAL: begin
                branch_nxt = (dst_r != src_r);
                carry_nxt  = (src_r > dst_r);
            end
            default: begin
                badop_nxt = 1'b1;
            end
        endcase
    end

    // One wait state: pready is a flop, so the access phase is two cycles
    assign access    = psel & penable;
    assign wr_commit = access & pready & pwrite & ~pslverr;
    assign mapped    = is_mapped(paddr);

    always @* begin
        rd_data = 32'h0000_0000;
        case (paddr)
            `BAL_ADDR_ACC:    rd_data = {24'h00_0000, acc_r};
            `BAL_ADDR_BREG:   rd_data = {24'h00_0000, breg_r};
            `BAL_ADDR_SRC:    rd_data = {24'h00_0000, src_r};
            `BAL_ADDR_DST:    rd_data = {24'h00_0000, dst_r};
            `BAL_ADDR_FLAGS:  rd_data = {29'h0000_0000, wrap_r, half_r,
                                         carry_r};
            `BAL_ADDR_CMD:    rd_data = {28'h000_0000, op_r};
            `BAL_ADDR_STATUS: rd_data = {29'h0000_0000, badop_r, divzero_r,
                                         branch_taken};
            default:          rd_data = 32'h0000_0000;
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access & ~pready;
            pslverr <= access & ~pready & ~mapped;
            if (access & ~pready & ~pwrite)
                prdata <= rd_data;
        end
    end

    // Bus writes and execution never meet: execution runs one edge after
    // the command write, when the bus is at best in a setup cycle
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r        <= `BAL_RST_BYTE;
            breg_r       <= `BAL_RST_BYTE;
            src_r        <= `BAL_RST_BYTE;
            dst_r        <= `BAL_RST_BYTE;
            carry_r      <= 1'b0;
            half_r       <= 1'b0;
            wrap_r       <= 1'b0;
            op_r         <= `BAL_OP_ADD;
            go_r         <= 1'b0;
            op_done      <= 1'b0;
            branch_taken <= 1'b0;
            divzero_r    <= 1'b0;
            badop_r      <= 1'b0;
        end else begin
            go_r    <= wr_commit & (paddr == `BAL_ADDR_CMD);
            op_done <= go_r;
            if (go_r) begin
                acc_r        <= acc_nxt;
                breg_r       <= breg_nxt;
                carry_r      <= carry_nxt;
                half_r       <= half_nxt;
                wrap_r       <= wrap_nxt;
                branch_taken <= branch_nxt;
                divzero_r    <= divzero_nxt;
                badop_r      <= badop_nxt;
            end else if (wr_commit) begin
                case (paddr)
                    `BAL_ADDR_ACC:   acc_r  <= pwdata[7:0];
                    `BAL_ADDR_BREG:  breg_r <= pwdata[7:0];
                    `BAL_ADDR_SRC:   src_r  <= pwdata[7:0];
                    `BAL_ADDR_DST:   dst_r  <= pwdata[7:0];
                    `BAL_ADDR_FLAGS: begin
                        carry_r <= pwdata[`BAL_FLG_CARRY];
                        half_r  <= pwdata[`BAL_FLG_HALF];
                        wrap_r  <= pwdata[`BAL_FLG_WRAP];
                    end
                    `BAL_ADDR_CMD:   op_r <= pwdata[`BAL_OP_W-1:0];
                    default: begin
                        op_r <= op_r;
                    end
                endcase
            end
        end
    end

endmodule // bal_alu

// [pkg/bal_defines.vh]
`ifndef BAL_DEFINES_VH
`define BAL_DEFINES_VH

// Register byte offsets
`define BAL_ADDR_ACC     8'h00
`define BAL_ADDR_BREG    8'h04
`define BAL_ADDR_SRC     8'h08
`define BAL_ADDR_DST     8'h0C
`define BAL_ADDR_FLAGS   8'h10
`define BAL_ADDR_CMD     8'h14
`define BAL_ADDR_STATUS  8'h18

// Flag register fields
`define BAL_FLG_CARRY    0
`define BAL_FLG_HALF     1
`define BAL_FLG_WRAP     2
`define BAL_FLG_W        3

// Status register fields
`define BAL_ST_BRANCH    0
`define BAL_ST_DIVZERO   1
`define BAL_ST_BADOP     2
`define BAL_ST_W         3

// Command opcodes, CMD[3:0]
`define BAL_OP_W         4
`define BAL_OP_ADD       4'h0
`define BAL_OP_SUM_WITH_CARRY_IN      4'h1
`define BAL_OP_SUBTRACT_WITH_BORROW      4'h2
`define BAL_OP_MUL       4'h3
`define BAL_OP_DIV       4'h4
`define BAL_OP_DA        4'h5
`define BAL_OP_RRC       4'h6
`define BAL_OP_RLC       4'h7
`define BAL_OP_COMPARE_BRANCH_UNEQUAL      4'h8

// Reset values
`define BAL_RST_BYTE     8'h00
`define BAL_RST_FLAGS    3'h0

// Decimal adjust and multiply constants
`define BAL_DA_LOW_FIX   8'h06
`define BAL_DA_HIGH_FIX  8'h60
`define BAL_DA_NIB_MAX   4'h9
`define BAL_DA_BCD_MAX   10'h099
`define BAL_MUL_MAX      16'h00FF

`endif

// [dv/bal_alu_sva.sv]
`timescale 1ns/1ps
`include "bal_defines.vh"
module bal_alu_sva (
    input wire        mclk,
    input wire        rst_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        op_done,
    input wire        branch_taken
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_cmd_taken;
        psel && penable && pready && pwrite && paddr == `BAL_ADDR_CMD
            && pwdata[3:0] <= `BAL_OP_COMPARE_BRANCH_UNEQUAL;
    endsequence
    sequence s_done_pulse;
        !op_done ##1 op_done ##1 !op_done;
    endsequence
    a_cmd_done: assert property (s_cmd_taken |=> s_done_pulse)
        else $error("operation done pulse missing or misplaced");
    a_done_cause: assert property ($rose(op_done) |->
        $past(psel && penable && pwrite && paddr == `BAL_ADDR_CMD, 2))
        else $error("done pulse without a command write");
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_ready_qual: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    a_err_map: assert property (pready && paddr[1:0] == 2'h0 |->
        pslverr == (paddr > `BAL_ADDR_STATUS))
        else $error("error response does not match address map");
    a_err_rdzero: assert property (pready && pslverr && !pwrite |->
        prdata == 32'h0000_0000)
        else $error("refused read returned nonzero data");
    a_branch_hold: assert property ($changed(branch_taken) |-> op_done)
        else $error("branch result changed without an operation");
endmodule // bal_alu_sva

bind bal_alu bal_alu_sva u_sva (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_done(op_done), .branch_taken(branch_taken));

// [dv/bal_core_model.sv]
`timescale 1ns/1ps
module bal_core_model (
    input  wire        mclk,
    output reg         psel,
    output reg         penable,
    output reg         pwrite,
    output reg  [7:0]  paddr,
    output reg  [31:0] pwdata,
    input  wire [31:0] prdata,
    input  wire        pready,
    input  wire        pslverr
);
    reg [31:0] rdata;
    reg        rerr;
    reg        hung;
    integer    n;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        hung = 1'b0;
    end
    // Call just after a rising edge; an idle cycle follows each transfer
    task xfer(input reg w, input reg [7:0] a, input reg [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge mclk);
                n = n + 1;
            end while (pready !== 1'b1 && n < 16);
            if (pready !== 1'b1) hung = 1'b1;
            rdata = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            pwdata <= ~d;
            @(posedge mclk);
        end
    endtask
endmodule // bal_core_model

// [dv/bal_alu_bench.sv]
`timescale 1ns/1ps
`include "bal_defines.vh"
module bal_alu_bench;
    reg         mclk;
    reg         rst_n;
    wire        psel, penable, pwrite, pready, pslverr, op_done, br;
    wire [7:0]  paddr;
    wire [31:0] pwdata, prdata;
    integer     errors;
    integer     cmp_count;
    integer     i;
    bal_alu dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .op_done(op_done), .branch_taken(br));
    bal_core_model core (.mclk(mclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    always #10 mclk = ~mclk;
    task final_report;
        begin
            if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    always @(posedge mclk) if (core.hung) begin
        errors = errors + 1;
        final_report;
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        begin
            core.xfer(1'b0, a, 32'h0000_0000);
            chk(core.rdata, exp);
        end
    endtask
    task run(input [3:0] op, input [7:0] a, b, s, d, input [2:0] f,
             input [7:0] ea, eb, input [2:0] ef, input ebr);
        begin
            core.xfer(1'b1, `BAL_ADDR_ACC, {24'h00_0000, a});
            core.xfer(1'b1, `BAL_ADDR_BREG, {24'h00_0000, b});
            core.xfer(1'b1, `BAL_ADDR_SRC, {24'h00_0000, s});
            core.xfer(1'b1, `BAL_ADDR_DST, {24'h00_0000, d});
            core.xfer(1'b1, `BAL_ADDR_FLAGS, {29'h0000_0000, f});
            core.xfer(1'b1, `BAL_ADDR_CMD, {28'h000_0000, op});
            rd(`BAL_ADDR_ACC, {24'h00_0000, ea});
            rd(`BAL_ADDR_BREG, {24'h00_0000, eb});
            rd(`BAL_ADDR_FLAGS, {29'h0000_0000, ef});
            chk({31'h0000_0000, br}, {31'h0000_0000, ebr});
        end
    endtask
    task t_bus;
        begin
            for (i = 0; i < 7; i = i + 1) rd(i * 4, 32'h0000_0000);
            rd(8'h1C, 32'h0000_0000);
            chk({31'h0000_0000, core.rerr}, 32'h0000_0001);
            core.xfer(1'b1, `BAL_ADDR_STATUS, 32'hFFFF_FFFF);
            rd(`BAL_ADDR_STATUS, 32'h0000_0000);
            run(4'h9, 8'h5A, 8'h00, 8'h00, 8'h00, 3'h5, 8'h5A, 8'h00, 3'h5, 0);
            rd(`BAL_ADDR_STATUS, 32'h0000_0004);
        end
    endtask
    task t_add;
        begin
            run(0, 8'h7F, 0, 8'h01, 0, 3'h1, 8'h80, 0, 3'h6, 0);
            run(0, 8'hFF, 0, 8'h01, 0, 3'h0, 8'h00, 0, 3'h3, 0);
            run(0, 8'h80, 0, 8'h80, 0, 3'h0, 8'h00, 0, 3'h5, 0);
            run(1, 8'h0E, 0, 8'h01, 0, 3'h1, 8'h10, 0, 3'h2, 0);
        end
    endtask
    task t_subtract_with_borrow;
        begin
            run(2, 8'h10, 0, 8'h01, 0, 3'h1, 8'h0E, 0, 3'h2, 0);
            run(2, 8'h80, 0, 8'h01, 0, 3'h0, 8'h7F, 0, 3'h6, 0);
            run(2, 8'h00, 0, 8'h01, 0, 3'h0, 8'hFF, 0, 3'h3, 0);
        end
    endtask
    task t_muldiv;
        begin
            run(3, 8'h10, 8'h10, 0, 0, 3'h3, 8'h00, 8'h01, 3'h6, 0);
            run(3, 8'h0F, 8'h11, 0, 0, 3'h5, 8'hFF, 8'h00, 3'h0, 0);
            run(4, 8'hFB, 8'h0A, 0, 0, 3'h7, 8'h19, 8'h01, 3'h2, 0);
            run(4, 8'h12, 8'h00, 0, 0, 3'h1, 8'h12, 8'h00, 3'h4, 0);
        end
    endtask
    task t_adjust;
        begin
            run(5, 8'h1C, 0, 0, 0, 3'h0, 8'h82, 0, 3'h0, 0);
            run(5, 8'h45, 0, 0, 0, 3'h2, 8'hAB, 0, 3'h3, 0);
            run(5, 8'h12, 0, 0, 0, 3'h1, 8'h72, 0, 3'h0, 0);
            run(5, 8'h12, 0, 0, 0, 3'h4, 8'h12, 0, 3'h4, 0);
        end
    endtask
    task t_rotate;
        begin
            run(6, 8'h01, 0, 0, 0, 3'h1, 8'h80, 0, 3'h1, 0);
            run(6, 8'h02, 0, 0, 0, 3'h6, 8'h01, 0, 3'h6, 0);
            run(7, 8'h80, 0, 0, 0, 3'h0, 8'h00, 0, 3'h1, 0);
            run(7, 8'h01, 0, 0, 0, 3'h1, 8'h03, 0, 3'h0, 0);
        end
    endtask
    task t_cmp;
        begin
            run(8, 8'h55, 0, 8'h20, 8'h10, 3'h0, 8'h55, 0, 3'h1, 1);
            run(8, 8'h55, 0, 8'h20, 8'h20, 3'h7, 8'h55, 0, 3'h6, 0);
            run(8, 8'h55, 0, 8'h20, 8'h30, 3'h0, 8'h55, 0, 3'h0, 1);
        end
    endtask
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        errors = 0;
        cmp_count = 0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_bus;
        t_add;
        t_subtract_with_borrow;
        t_muldiv;
        t_adjust;
        t_rotate;
        t_cmp;
        final_report;
    end
endmodule // bal_alu_bench
